// ==== pkg/quad_dac_defs.svh ====
`ifndef QUAD_DAC_DEFS_SVH
`define QUAD_DAC_DEFS_SVH

// Serial word layout, most significant bit first on the wire
`define WORD_W          16
`define CODE_W          10
`define CHAN_N          4
`define BIT_CNT_W       5
`define WORD_BITS       5'h10
`define FLD_ADDR_HI     15
`define FLD_ADDR_LO     14
`define FLD_CTRL_HI     13
`define FLD_CTRL_LO     12
`define FLD_CODE_HI     11
`define FLD_CODE_LO     2
`define FLD_SUB_HI      1
`define FLD_SUB_LO      0

// Address/control codes
`define OP_NOP          4'h0
`define OP_USER_LOW     4'h2
`define OP_UPDATE_ALL   4'h4
`define OP_USER_HIGH    4'h6
`define OP_LOAD_ALL     4'h8
`define OP_ECHO_FALL    4'hA
`define OP_SLEEP        4'hC
`define OP_ECHO_RISE    4'hE
`define CTL_LOAD_ONE    2'h1
`define CTL_LOAD_UPDATE 2'h3
`define SUB_ZERO        2'h0

// Wishbone register map (byte addresses)
`define ADR_W           8
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_LAST_WORD   8'h08
`define REG_WORD_COUNT  8'h0C
`define REG_CHAN_BASE   8'h10
`define REG_CHAN_LAST   8'h1C

// Field positions and reset values
`define CTRL_ENABLE_BIT 0
`define CTRL_WIPE_BIT   1
`define CTRL_RESET      1'h1
`define ST_SLEEP_BIT    0
`define ST_USER_BIT     1
`define ST_ECHO_BIT     2
`define ST_LOCKOUT_BIT  3
`define ST_SETTLED_BIT  4
`define ST_BAD_WORD_BIT 5
`define ST_REFUSED_BIT  6
`define CHAN_INPUT_LO   16

// Output settling time after leaving shutdown
`define SETTLE_TIME_NS  20000
`define CORE_PERIOD_NS  25
`define SETTLE_CYCLES   ((`SETTLE_TIME_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define SETTLE_CNT_W    10

`endif

// ==== pkg/quad_dac_pkg.sv ====
package quad_dac_pkg;

  // One serial word as shifted in
  typedef struct packed {
    logic [1:0] channel_address_bits;
    logic [1:0] control_code_bits;
    logic [9:0] code_bits;
    logic [1:0] sub_bits;
  } serial_word_t;

  // Pins from outside the core clock domain
  typedef struct packed {
    logic serial_clk;
    logic select_n;
    logic serial_data;
    logic wipe_all_n;
    logic sleep_lockout_n;
  } pin_bundle_t;

  // High-impedance controls for the analog section
  typedef struct packed {
    logic amp_hiz;
    logic reference_pair_one_hiz;
    logic reference_pair_two_hiz;
  } analog_ctrl_t;

  // Four 10-bit channel codes, channel A in slot 0
  typedef logic [3:0][9:0] code_bank_t;

  typedef enum logic {ECHO_ON_FALL, ECHO_ON_RISE} echo_edge_t;

  typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_t;

endpackage

// ==== rtl/dac_channel.sv ====
`timescale 1ns/1ps
`include "quad_dac_defs.svh"

// One channel: input register followed by DAC register
module dac_channel #(
  parameter int CODE_W = `CODE_W
) (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  // Load controls
  input  wire logic              wipe_in,
  input  wire logic              load_input_in,
  input  wire logic              update_dac_in,
  input  wire logic [CODE_W-1:0] code_in,
  // Register contents
  output logic      [CODE_W-1:0] input_code_out,
  output logic      [CODE_W-1:0] dac_code_out
);

  // Input register holds data until a DAC update
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      input_code_out <= '0;
    end else if (wipe_in) begin
      input_code_out <= '0;
    end else if (load_input_in) begin
      input_code_out <= code_in;
    end
  end

  // Same-cycle load and update passes the new code straight through
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dac_code_out <= '0;
    end else if (wipe_in) begin
      dac_code_out <= '0;
    end else if (update_dac_in) begin
      dac_code_out <= load_input_in ? code_in : input_code_out;
    end
  end

endmodule

// ==== rtl/quad_dac_serial_control.sv ====
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "quad_dac_defs.svh"

// Summary of operation
// - wipe pin clears registers, outputs to zero
// - serial logic works only while select low
// - lockout low makes shutdown command ignored
// - one shared 16-bit in/out shift register
// - each channel has input then DAC register
// - word is address, control, code, sub-bits
// - code 1100 enters shutdown if lockout high
// - lockout must be high to accept shutdown
// - shutdown sets amplifiers and references high-Z
// - link and input registers live during shutdown
// - DAC update or wipe leaves shutdown
// - shift register contents appear on echo pin
// - load input only, or load DAC directly
// - one command copies all inputs to DACs
// - code is unsigned 10-bit, 0 to 1023
// - A,B share reference one; C,D reference two
// - sample on clock rise, commit on select rise
// - address picks channel; 01 load, 11 load+update
// - 0100 update all, 1000 load all, 0000 nothing
// - user output and echo edge commands
module quad_dac_serial_control
  import quad_dac_pkg::*;
#(
  parameter int CODE_W        = `CODE_W,
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // Core clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               reset_n_in,
  // Serial link pins
  input  wire logic               serial_clk_in,
  input  wire logic               select_n_in,
  input  wire logic               serial_data_in,
  output logic                    echo_out,
  // Control pins
  input  wire logic               wipe_all_n_in,
  input  wire logic               sleep_lockout_n_in,
  output logic                    user_output_out,
  // Analog section controls
  output code_bank_t              dac_code_out,
  output analog_ctrl_t            analog_ctrl_out,
  output logic                    outputs_settled_out,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [`ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o
);

  pin_bundle_t                pins_in;
  pin_bundle_t                sync1_q;
  pin_bundle_t                sync2_q;
  logic                       sclk_prev_q;
  logic                       sel_prev_q;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       sel_fall;
  logic                       sel_rise;
  logic                       wipe;
  logic                       lockout_high;
  link_state_t                link_state_q;
  logic [`WORD_W-1:0]         shift_q;
  logic [`BIT_CNT_W-1:0]      bit_cnt_q;
  logic                       echo_q;
  echo_edge_t                 echo_mode_q;
  logic                       commit;
  logic                       short_word;
  serial_word_t               word;
  logic [3:0]                 op;
  logic                       subs_ok;
  logic                       load_one;
  logic                       load_all;
  logic                       update_all;
  logic                       sleep_req;
  logic [`CHAN_N-1:0]         load_input;
  logic                       sleep_q;
  logic                       user_q;
  logic                       bad_word_q;
  logic                       refused_q;
  logic [`SETTLE_CNT_W-1:0]   settle_cnt_q;
  logic [`WORD_W-1:0]         last_word_q;
  logic [15:0]                word_count_q;
  logic                       enable_q;
  logic                       soft_wipe_q;
  logic                       wb_req;
  logic                       wb_wr;
  logic                       ack_q;
  logic [31:0]                rd_d;
  logic [31:0]                dat_q;
  code_bank_t                 input_codes;
  code_bank_t                 dac_codes;

  assign pins_in = '{serial_clk:      serial_clk_in,
                     select_n:        select_n_in,
                     serial_data:     serial_data_in,
                     wipe_all_n:      wipe_all_n_in,
                     sleep_lockout_n: sleep_lockout_n_in};

  // Two-stage synchroniser for every pin; only stage two is read
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_q <= '{serial_clk: 1'b0, select_n: 1'b1, serial_data: 1'b0,
                   wipe_all_n: 1'b1, sleep_lockout_n: 1'b1};
      sync2_q <= '{serial_clk: 1'b0, select_n: 1'b1, serial_data: 1'b0,
                   wipe_all_n: 1'b1, sleep_lockout_n: 1'b1};
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
    end
  end

  // Edge history of the synchronised serial clock and select
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_prev_q <= 1'b0;
      sel_prev_q  <= 1'b1;
    end else begin
      sclk_prev_q <= sync2_q.serial_clk;
      sel_prev_q  <= sync2_q.select_n;
    end
  end

  // Edge events, one core cycle each
  assign sclk_rise    = sync2_q.serial_clk & ~sclk_prev_q;
  assign sclk_fall    = ~sync2_q.serial_clk & sclk_prev_q;
  assign sel_fall     = ~sync2_q.select_n & sel_prev_q;
  assign sel_rise     = sync2_q.select_n & ~sel_prev_q;
  assign wipe         = ~sync2_q.wipe_all_n | soft_wipe_q;
  assign lockout_high = sync2_q.sleep_lockout_n;

  // Frame tracking: select low opens a frame, select high closes it
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_state_q <= LINK_IDLE;
    end else begin
      unique case (link_state_q)
        LINK_IDLE: begin
          if (sel_fall && enable_q) begin
            link_state_q <= LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          if (sync2_q.select_n || !enable_q) begin
            link_state_q <= LINK_IDLE;
          end
        end
      endcase
    end
  end

  // Shared shift register, sampled on serial clock rise
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_q <= '0;
    end else if (wipe) begin
      shift_q <= '0;
    end else if (link_state_q == LINK_SHIFT && sclk_rise) begin
      shift_q <= {shift_q[`WORD_W-2:0], sync2_q.serial_data};
    end
  end

  // Bit count restarts on each select fall and saturates at a full word
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_cnt_q <= '0;
    end else if (sel_fall) begin
      bit_cnt_q <= '0;
    end else if (link_state_q == LINK_SHIFT && sclk_rise &&
                 bit_cnt_q != `WORD_BITS) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  // Echo takes the bit leaving the register, on the chosen clock edge
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      echo_q <= 1'b0;
    end else if (wipe) begin
      echo_q <= 1'b0;
    end else if (link_state_q == LINK_SHIFT &&
                 ((echo_mode_q == ECHO_ON_RISE && sclk_rise) ||
                  (echo_mode_q == ECHO_ON_FALL && sclk_fall))) begin
      echo_q <= shift_q[`WORD_W-1];
    end
  end

  // Longer frames keep the last sixteen bits, which suits daisy chains
  assign commit     = link_state_q == LINK_SHIFT && sel_rise &&
                      bit_cnt_q == `WORD_BITS;
  assign short_word = link_state_q == LINK_SHIFT && sel_rise &&
                      bit_cnt_q != `WORD_BITS;

  // Command decode of the committed word
  assign word    = serial_word_t'(shift_q);
  assign op      = {word.channel_address_bits, word.control_code_bits};
  assign subs_ok = word.sub_bits == `SUB_ZERO;
  assign load_one = commit && subs_ok &&
                    (word.control_code_bits == `CTL_LOAD_ONE ||
                     word.control_code_bits == `CTL_LOAD_UPDATE);
  assign load_all = commit && subs_ok && op == `OP_LOAD_ALL;
  assign sleep_req = commit && op == `OP_SLEEP;
  assign update_all = load_all ||
                      (commit && subs_ok &&
                       word.control_code_bits == `CTL_LOAD_UPDATE) ||
                      (commit && (op == `OP_UPDATE_ALL ||
                                  op == `OP_ECHO_RISE ||
                                  op == `OP_ECHO_FALL));

  // Per-channel input load strobes; 0000 and others load nothing
  always_comb begin
    for (int i = 0; i < `CHAN_N; i++) begin
      load_input[i] = load_all ||
                      (load_one && word.channel_address_bits == 2'(i));
    end
  end

  // Four identical channels
  for (genvar g = 0; g < `CHAN_N; g++) begin : g_chan
    dac_channel #(
      .CODE_W         (CODE_W)
    ) u_chan (
      .core_clk_in    (core_clk_in),
      .reset_n_in     (reset_n_in),
      .wipe_in        (wipe),
      .load_input_in  (load_input[g]),
      .update_dac_in  (update_all),
      .code_in        (word.code_bits),
      .input_code_out (input_codes[g]),
      .dac_code_out   (dac_codes[g])
    );
  end

  // Shutdown state; lockout low leaves the part powered
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sleep_q <= 1'b0;
    end else if (wipe) begin
      sleep_q <= 1'b0;
    end else if (sleep_req && lockout_high) begin
      sleep_q <= 1'b1;
    end else if (update_all) begin
      sleep_q <= 1'b0;
    end
  end

  // User output and echo edge selection
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      user_q      <= 1'b0;
      echo_mode_q <= ECHO_ON_FALL;
    end else if (wipe) begin
      user_q      <= 1'b0;
      echo_mode_q <= ECHO_ON_FALL;
    end else if (commit) begin
      if (op == `OP_USER_LOW) begin
        user_q <= 1'b0;
      end else if (op == `OP_USER_HIGH) begin
        user_q <= 1'b1;
      end
      if (op == `OP_ECHO_RISE) begin
        echo_mode_q <= ECHO_ON_RISE;
      end else if (op == `OP_ECHO_FALL) begin
        echo_mode_q <= ECHO_ON_FALL;
      end
    end
  end

  // Settling timer after reset or wake; reported, never enforced
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      settle_cnt_q <= `SETTLE_CNT_W'(SETTLE_CYCLES);
    end else if (sleep_q && (update_all || wipe)) begin
      settle_cnt_q <= `SETTLE_CNT_W'(SETTLE_CYCLES);
    end else if (settle_cnt_q != '0) begin
      settle_cnt_q <= settle_cnt_q - 1'b1;
    end
  end

  // Sticky error flags; a new event beats a clear in the same cycle
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bad_word_q <= 1'b0;
      refused_q  <= 1'b0;
    end else begin
      if (short_word) begin
        bad_word_q <= 1'b1;
      end else if (wb_wr && wb_adr_i == `REG_STATUS && wb_sel_i[0] &&
                   wb_dat_i[`ST_BAD_WORD_BIT]) begin
        bad_word_q <= 1'b0;
      end
      if (sleep_req && !lockout_high) begin
        refused_q <= 1'b1;
      end else if (wb_wr && wb_adr_i == `REG_STATUS && wb_sel_i[0] &&
                   wb_dat_i[`ST_REFUSED_BIT]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // Record of accepted words for software
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      last_word_q  <= '0;
      word_count_q <= '0;
    end else if (commit) begin
      last_word_q  <= shift_q;
      word_count_q <= word_count_q + 1'b1;
    end
  end

  // Control register; the wipe bit is a self-clearing pulse
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable_q    <= `CTRL_RESET;
      soft_wipe_q <= 1'b0;
    end else begin
      soft_wipe_q <= 1'b0;
      if (wb_wr && wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
        enable_q    <= wb_dat_i[`CTRL_ENABLE_BIT];
        soft_wipe_q <= wb_dat_i[`CTRL_WIPE_BIT];
      end
    end
  end

  // Bus handshake: ack one cycle after the request, write at the ack edge
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  // Read mux; unmapped addresses read as zero and still acknowledge
  always_comb begin
    rd_d = '0;
    if (wb_adr_i >= `REG_CHAN_BASE && wb_adr_i <= `REG_CHAN_LAST &&
        wb_adr_i[1:0] == 2'h0) begin
      rd_d[`CHAN_INPUT_LO +: `CODE_W] = input_codes[wb_adr_i[3:2]];
      rd_d[`CODE_W-1:0]               = dac_codes[wb_adr_i[3:2]];
    end else begin
      unique case (wb_adr_i)
        `REG_CTRL: begin
          rd_d[`CTRL_ENABLE_BIT] = enable_q;
        end
        `REG_STATUS: begin
          rd_d[`ST_SLEEP_BIT]    = sleep_q;
          rd_d[`ST_USER_BIT]     = user_q;
          rd_d[`ST_ECHO_BIT]     = echo_mode_q == ECHO_ON_RISE;
          rd_d[`ST_LOCKOUT_BIT]  = lockout_high;
          rd_d[`ST_SETTLED_BIT]  = settle_cnt_q == '0;
          rd_d[`ST_BAD_WORD_BIT] = bad_word_q;
          rd_d[`ST_REFUSED_BIT]  = refused_q;
        end
        `REG_LAST_WORD: begin
          rd_d[`WORD_W-1:0] = last_word_q;
        end
        `REG_WORD_COUNT: begin
          rd_d[15:0] = word_count_q;
        end
        default: begin
          rd_d = '0;
        end
      endcase
    end
  end

  // Read data captured with the request and held through the ack
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dat_q <= '0;
    end else if (wb_req) begin
      dat_q <= rd_d;
    end
  end

  // Outputs: codes drive the ladders; pair one feeds A and B
  assign dac_code_out        = dac_codes;
  assign analog_ctrl_out     = '{amp_hiz:                sleep_q,
                                 reference_pair_one_hiz: sleep_q,
                                 reference_pair_two_hiz: sleep_q};
  assign outputs_settled_out = settle_cnt_q == '0;
  assign user_output_out     = user_q;
  assign echo_out            = echo_q;
  assign wb_dat_o            = dat_q;
  assign wb_ack_o            = ack_q;

endmodule

// ==== testbench/host_link_model.sv ====
`timescale 1ns/1ps

// Behavioural host on the far side of the serial link
module host_link_model (
  // Timing reference and echo return
  input  wire logic        core_clk_in,
  input  wire logic        echo_in,
  // Link drives
  output logic             serial_clk_out,
  output logic             select_n_out,
  output logic             serial_data_out,
  output logic [15:0]      rx_out
);
  // Clock idles low and stands still outside frames
  initial begin
    serial_clk_out = 1'b0;
    select_n_out = 1'b1;
    serial_data_out = 1'b0;
    rx_out = 16'h0;
  end

  // Send the top n bits of w; 4 core cycles per half period gives 200 ns
  task automatic send(input logic [15:0] w, input int n);
    int i;
    @(posedge core_clk_in);
    select_n_out <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    for (i = 15; i > 15 - n; i--) begin
      serial_data_out <= w[i];
      repeat (4) @(posedge core_clk_in);
      serial_clk_out <= 1'b1;
      rx_out <= {rx_out[14:0], echo_in};
      repeat (4) @(posedge core_clk_in);
      serial_clk_out <= 1'b0;
    end
    repeat (4) @(posedge core_clk_in);
    // Released line shows a changed level, not the last bit
    select_n_out <= 1'b1;
    serial_data_out <= ~serial_data_out;
  endtask
endmodule

// ==== testbench/quad_dac_asserts.sv ====
`timescale 1ns/1ps

// Pin-level checker for the serial DAC control block
module quad_dac_asserts
  import quad_dac_pkg::*;
#(
  parameter int SETTLE_CYCLES = 800
) (
  // Clock and reset
  input wire logic         core_clk_in,
  input wire logic         reset_n_in,
  // Pins and outputs
  input wire logic         select_n_in,
  input wire logic         wipe_all_n_in,
  input wire logic         sleep_lockout_n_in,
  input wire logic         echo_out,
  input wire logic         user_output_out,
  input wire code_bank_t   dac_code_out,
  input wire analog_ctrl_t analog_ctrl_out,
  input wire logic         outputs_settled_out,
  // Bus handshake
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_ack_o
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Unsettled run length, cleared while in shutdown or settled
  logic [15:0] wait_q;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      wait_q <= 16'h0;
    else if (outputs_settled_out || analog_ctrl_out.amp_hiz)
      wait_q <= 16'h0;
    else
      wait_q <= wait_q + 16'h1;
  end

  // Link idle with nothing else able to touch the registers; lockout held low
  sequence quiet8;
    (select_n_in && wipe_all_n_in && !wb_cyc_i)[*8];
  endsequence
  sequence locked8;
    (!sleep_lockout_n_in)[*8];
  endsequence

  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  AST_HIZ_TIED: assert property (
    analog_ctrl_out.reference_pair_one_hiz == analog_ctrl_out.amp_hiz &&
    analog_ctrl_out.reference_pair_two_hiz == analog_ctrl_out.amp_hiz)
    else $error("analog high-Z controls disagree");
  AST_LOCKOUT: assert property (
    locked8 |=> !$rose(analog_ctrl_out.amp_hiz))
    else $error("shutdown entered with lockout low");
  AST_IDLE_DAC: assert property (quiet8 |-> $stable(dac_code_out))
    else $error("DAC codes moved while deselected");
  AST_IDLE_PINS: assert property (
    quiet8 |-> $stable({echo_out, user_output_out}))
    else $error("echo or user pin moved while deselected");
  AST_IDLE_SLEEP: assert property (quiet8 |-> $stable(analog_ctrl_out))
    else $error("shutdown changed without a committed word");
  AST_WIPE: assert property ((!wipe_all_n_in)[*6] |->
    dac_code_out == '0 && !user_output_out && !echo_out &&
    !analog_ctrl_out.amp_hiz)
    else $error("wipe left state behind");
  AST_SETTLE_DROP: assert property (
    $fell(analog_ctrl_out.amp_hiz) |-> ##[0:2] !outputs_settled_out)
    else $error("settled flag not dropped on wake");
  AST_SETTLE_BOUND: assert property (
    wait_q <= 16'(SETTLE_CYCLES + 4))
    else $error("settled flag late");
endmodule

bind quad_dac_serial_control quad_dac_asserts #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) u_quad_dac_asserts (
  .core_clk_in, .reset_n_in, .select_n_in, .wipe_all_n_in,
  .sleep_lockout_n_in, .echo_out, .user_output_out, .dac_code_out,
  .analog_ctrl_out, .outputs_settled_out, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o
);

// ==== testbench/quad_dac_serial_control_bench.sv ====
`timescale 1ns/1ps
`include "quad_dac_defs.svh"

module quad_dac_serial_control_bench
  import quad_dac_pkg::*;
;
  // Drives
  logic         core_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         wipe_n = 1'b1;
  logic         lock_n = 1'b1;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  wdat = 32'h0;
  // Observed
  logic         echo, user, settled, ack, sclk, sel_n, sdat;
  code_bank_t   dac;
  analog_ctrl_t actl;
  logic [31:0]  rdat;
  logic [15:0]  rx;
  int           fails = 0;
  int           n_tests = 0;
  int           cycles = 0;

  always #12.5 core_clk = ~core_clk;

  quad_dac_serial_control #(.SETTLE_CYCLES(8)) u_quad_dac_serial_control (
    .core_clk_in(core_clk), .reset_n_in(reset_n), .serial_clk_in(sclk),
    .select_n_in(sel_n), .serial_data_in(sdat), .echo_out(echo),
    .wipe_all_n_in(wipe_n), .sleep_lockout_n_in(lock_n),
    .user_output_out(user), .dac_code_out(dac), .analog_ctrl_out(actl),
    .outputs_settled_out(settled), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));

  host_link_model u_host_link_model (
    .core_clk_in(core_clk), .echo_in(echo), .serial_clk_out(sclk),
    .select_n_out(sel_n), .serial_data_out(sdat), .rx_out(rx));

  task automatic check(input string what, input logic [39:0] seen,
                       input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle; waits for ack without assuming its latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // One full word, then time for the commit to land
  task automatic go(input logic [15:0] w);
    u_host_link_model.send(w, 16);
    repeat (10) @(posedge core_clk);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    check("bank", dac, '0);
    check("pins", 40'({echo, user, actl}), 40'h0);
    wb(1'b0, `REG_CTRL, 32'h0, q);
    check("ctrl", 40'(q), 40'h1);
    wb(1'b0, 8'h40, 32'h0, q);
    check("unmapped", 40'(q), 40'h0);
    repeat (12) @(posedge core_clk);
    check("settled", 40'(settled), 40'h1);
    $display("reset test done");
  endtask

  task automatic t_load();
    logic [31:0] q;
    for (int i = 0; i < 4; i++)
      go({2'(i), `CTL_LOAD_ONE, 10'(i + 1), 2'h0});
    check("bank", dac, '0);
    go({`OP_UPDATE_ALL, 12'h0});
    check("bank", dac, {10'h4, 10'h3, 10'h2, 10'h1});
    go({2'h2, `CTL_LOAD_UPDATE, 10'h3FF, 2'h0});
    check("bank", dac, {10'h4, 10'h3FF, 10'h2, 10'h1});
    go({`OP_LOAD_ALL, 10'h2AA, 2'h0});
    check("bank", dac, {4{10'h2AA}});
    wb(1'b0, `REG_LAST_WORD, 32'h0, q);
    check("last", 40'(q[15:0]), 40'h8AA8);
    go({`OP_NOP, 12'hFFF});
    check("bank", dac, {4{10'h2AA}});
    $display("load test done");
  endtask

  task automatic t_modes();
    logic [31:0] q;
    go({`OP_USER_HIGH, 12'h0});
    check("user", 40'(user), 40'h1);
    go({`OP_USER_LOW, 12'h0});
    check("user", 40'(user), 40'h0);
    go({2'h0, `CTL_LOAD_ONE, 10'h123, 2'h0});
    go({`OP_ECHO_RISE, 12'h0});
    check("bank", dac, {10'h2AA, 10'h2AA, 10'h2AA, 10'h123});
    wb(1'b0, `REG_STATUS, 32'h0, q);
    check("rise", 40'(q[`ST_ECHO_BIT]), 40'h1);
    go({`OP_ECHO_FALL, 12'h0});
    wb(1'b0, `REG_STATUS, 32'h0, q);
    check("rise", 40'(q[`ST_ECHO_BIT]), 40'h0);
    $display("mode test done");
  endtask

  task automatic t_sleep();
    @(posedge core_clk);
    lock_n <= 1'b0;
    go({`OP_SLEEP, 12'h0});
    check("hiz", 40'(actl), 40'h0);
    lock_n <= 1'b1;
    go({`OP_SLEEP, 12'h0});
    check("hiz", 40'(actl), 40'h7);
    go({2'h0, `CTL_LOAD_ONE, 10'h011, 2'h0});
    check("hiz", 40'(actl), 40'h7);
    go({`OP_UPDATE_ALL, 12'h0});
    check("hiz", 40'(actl), 40'h0);
    check("bank", dac, {10'h2AA, 10'h2AA, 10'h2AA, 10'h011});
    repeat (12) @(posedge core_clk);
    check("settled", 40'(settled), 40'h1);
    $display("sleep test done");
  endtask

  // Partial frame first; the next select fall must restart the count
  task automatic t_short();
    u_host_link_model.send({2'h3, `CTL_LOAD_UPDATE, 10'h0F0, 2'h0}, 8);
    repeat (10) @(posedge core_clk);
    check("bank", dac, {10'h2AA, 10'h2AA, 10'h2AA, 10'h011});
    go({2'h3, `CTL_LOAD_UPDATE, 10'h0F0, 2'h0});
    check("bank", dac, {10'h0F0, 10'h2AA, 10'h2AA, 10'h011});
    $display("short word test done");
  endtask

  task automatic t_echo();
    go({2'h1, `CTL_LOAD_ONE, 10'h2C3, 2'h0});
    go({`OP_NOP, 12'h000});
    check("echo", 40'(rx), 40'h5B0C);
    $display("echo test done");
  endtask

  task automatic t_wipe();
    go({`OP_USER_HIGH, 12'h0});
    @(posedge core_clk);
    wipe_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    check("bank", dac, '0);
    check("pins", 40'({echo, user, actl}), 40'h0);
    wipe_n <= 1'b1;
    repeat (12) @(posedge core_clk);
    $display("wipe test done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 3200 cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_load();
    t_modes();
    t_sleep();
    t_short();
    t_echo();
    t_wipe();
    conclude();
  end
endmodule
